// file: rtl/port_split_link_recovery.sv
// Port split power control and link recovery for downstream ports 5 and 6.
// Assumes configuration writes arrive from the hub's SMBus or OTP loader, one clock domain.
// Behaviour
// RQ1 - Splitting exists only on ports 5 and 6
// RQ2 - Settings load from SMBus config stage or OTP
// RQ3 - Normal port power pin keeps USB 2.0 control
// RQ4 - Split pin powers SuperSpeed half, no overcurrent
// RQ5 - Port 5 select 0x42 option A, 0x05 B
// RQ6 - Port 6 select 0x06 option A, 0x04 B
// RQ7 - No valid link for timeout toggles split power
// RQ8 - Timer clears and restarts on every timeout
// RQ9 - Invalid means one code 0x4-0x9 throughout
// RQ10 - Timeout field at 0x4171, zero disables, default 1s
// RQ11 - Codes: 100/250/750ms, 101b 1s, 110b 2s
// RQ12 - Split power held low for programmed duration
// RQ13 - Duration is 350ms plus 10ms per step
// RQ14 - Duration only for link resets, cleared after
// RQ15 - After pulse, power high and monitoring restarts
`timescale 1ns/10ps
`default_nettype none
module port_split_link_recovery
#(
	parameter int unsigned TICK_CYCLES = split_pkg::MS_CYCLES
)
(
	// Clock, reset and clock enable
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	// Configuration access
	input  wire logic        config_stage,
	input  wire logic        cfg_write,
	input  wire logic        otp_write,
	input  wire logic        cfg_read,
	input  wire logic [15:0] cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	output logic      [7:0]  cfg_rdata,
	// Normal port power for the USB 2.0 halves of ports 5 and 6
	input  wire logic [1:0]  port_power_request,
	output logic      [1:0]  port_power_control_pin,
	// Link state of ports 5 and 6
	input  wire logic [3:0]  link_state_status_p5,
	input  wire logic [3:0]  link_state_status_p6,
	// Split power pins, value and enable
	output logic             port5_option_a_pin,
	output logic             port5_option_a_pin_oe,
	output logic             port5_option_b_pin,
	output logic             port5_option_b_pin_oe,
	output logic             port6_option_a_pin,
	output logic             port6_option_a_pin_oe,
	output logic             port6_option_b_pin,
	output logic             port6_option_b_pin_oe
);
	import split_pkg::*;

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	typedef struct packed
	{
		logic [7:0]  sel5;
		logic [7:0]  sel6;
		logic [2:0]  timeout_code;
		logic [7:0]  off_time;
		logic [15:0] tick_count;
		logic        ms_tick;
		logic [7:0]  rdata;
		logic [1:0]  ppc;
		logic        p5a;
		logic        p5a_oe;
		logic        p5b;
		logic        p5b_oe;
		logic        p6a;
		logic        p6a_oe;
		logic        p6b;
		logic        p6b_oe;
	} top_s;

	top_s        r;
	top_s        next_r;
	logic        split5;
	logic        split6;
	logic        wr_ok;
	logic [11:0] timeout_ms;
	logic [11:0] off_ms;
	logic [1:0]  mon_power;

	// Timeout code to milliseconds; reserved codes behave as disabled
	function automatic logic [11:0] timeout_ms_of(input logic [2:0] code);
		logic [11:0] ms;
		case (code)
			TO_100MS: ms = MS_100;  // [RQ11]
			TO_250MS: ms = MS_250;
			TO_750MS: ms = MS_750;
			TO_1S:    ms = MS_1000; // [RQ11]
			TO_2S:    ms = MS_2000; // [RQ11]
			default:  ms = MS_NONE; // [RQ10]
		endcase
		return ms;
	endfunction

	// Decoded settings: timeout and duration shared by both monitors, split enables per port
	assign timeout_ms = timeout_ms_of(r.timeout_code); // [RQ10]
	assign off_ms     = 12'(OFF_BASE_MS + 12'(OFF_STEP_MS * {4'h0, r.off_time})); // [RQ13]
	assign split5     = (r.sel5 == P5_OPT_A) || (r.sel5 == P5_OPT_B); // [RQ5]
	assign split6     = (r.sel6 == P6_OPT_A) || (r.sel6 == P6_OPT_B); // [RQ6]
	// SMBus writes only count in the config stage; OTP loads always do
	assign wr_ok      = (cfg_write && config_stage) || otp_write; // [RQ2]

	// One watchdog per splittable port; no other port has one
	split_link_monitor u_mon5 // [RQ1]
	(
		.clock         (clock),
		.rst           (rst),
		.ce            (ce),
		.ms_tick       (r.ms_tick),
		.split_enabled (split5),
		.timeout_ms    (timeout_ms),
		.off_ms        (off_ms),
		.link_state    (link_state_status_p5),
		.power         (mon_power[0])
	);

	split_link_monitor u_mon6 // [RQ1]
	(
		.clock         (clock),
		.rst           (rst),
		.ce            (ce),
		.ms_tick       (r.ms_tick),
		.split_enabled (split6),
		.timeout_ms    (timeout_ms),
		.off_ms        (off_ms),
		.link_state    (link_state_status_p6),
		.power         (mon_power[1])
	);

	// Register file, millisecond tick and pin drive
	always_comb
	begin
		next_r = r;
		// Millisecond prescaler
		if (r.tick_count == TICK_LAST)
		begin
			next_r.tick_count = TICK_ZERO;
			next_r.ms_tick    = 1'b1;
		end
		else
		begin
			next_r.tick_count = 16'(r.tick_count + TICK_ONE);
			next_r.ms_tick    = 1'b0;
		end
		// Writes
		if (wr_ok)
		begin
			case (cfg_addr)
				ADDR_PORT5_SEL: next_r.sel5         = cfg_wdata; // [RQ5]
				ADDR_PORT6_SEL: next_r.sel6         = cfg_wdata; // [RQ6]
				ADDR_TIMEOUT:   next_r.timeout_code = cfg_wdata[2:0]; // [RQ10]
				ADDR_OFF_TIME:  next_r.off_time     = cfg_wdata; // [RQ12]
				default:        next_r.sel5         = r.sel5;
			endcase
		end
		// Reads; unused bits and unmapped addresses read zero
		if (cfg_read)
		begin
			case (cfg_addr)
				ADDR_PORT5_SEL: next_r.rdata = r.sel5;
				ADDR_PORT6_SEL: next_r.rdata = r.sel6;
				ADDR_TIMEOUT:   next_r.rdata = {5'h00, r.timeout_code};
				ADDR_OFF_TIME:  next_r.rdata = r.off_time;
				default:        next_r.rdata = RDATA_RESET;
			endcase
		end
		// USB 2.0 halves follow the normal request, untouched by splitting
		next_r.ppc    = port_power_request; // [RQ3]
		// Only the selected option pin is driven; no overcurrent sense is attached
		next_r.p5a_oe = (r.sel5 == P5_OPT_A); // [RQ4] [RQ5]
		next_r.p5b_oe = (r.sel5 == P5_OPT_B); // [RQ5]
		next_r.p6a_oe = (r.sel6 == P6_OPT_A); // [RQ6]
		next_r.p6b_oe = (r.sel6 == P6_OPT_B); // [RQ6]
		next_r.p5a    = next_r.p5a_oe & mon_power[0]; // [RQ4]
		next_r.p5b    = next_r.p5b_oe & mon_power[0];
		next_r.p6a    = next_r.p6a_oe & mon_power[1];
		next_r.p6b    = next_r.p6b_oe & mon_power[1];
	end

	// State register, frozen while ce is low
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			r.sel5         <= SEL_RESET;
			r.sel6         <= SEL_RESET;
			r.timeout_code <= TIMEOUT_RESET;
			r.off_time     <= OFF_TIME_RESET;
			r.tick_count   <= TICK_ZERO;
			r.ms_tick      <= 1'b0;
			r.rdata        <= RDATA_RESET;
			r.ppc          <= 2'b00;
			r.p5a          <= 1'b0;
			r.p5a_oe       <= 1'b0;
			r.p5b          <= 1'b0;
			r.p5b_oe       <= 1'b0;
			r.p6a          <= 1'b0;
			r.p6a_oe       <= 1'b0;
			r.p6b          <= 1'b0;
			r.p6b_oe       <= 1'b0;
		end
		else if (ce)
			r <= next_r;
	end

	// Outputs straight from the state register
	assign cfg_rdata              = r.rdata;
	assign port_power_control_pin = r.ppc;
	assign port5_option_a_pin     = r.p5a;
	assign port5_option_a_pin_oe  = r.p5a_oe;
	assign port5_option_b_pin     = r.p5b;
	assign port5_option_b_pin_oe  = r.p5b_oe;
	assign port6_option_a_pin     = r.p6a;
	assign port6_option_a_pin_oe  = r.p6a_oe;
	assign port6_option_b_pin     = r.p6b;
	assign port6_option_b_pin_oe  = r.p6b_oe;

	// USB 2.0 power follows its request one cycle later
	a_ppc_follows: assert property (@(posedge clock) disable iff (rst) // [RQ3]
		ce |=> port_power_control_pin == $past(port_power_request))
		else $error("port power pin did not follow its request");

	// SMBus writes outside the config stage leave the timeout unchanged
	a_write_blocked: assert property (@(posedge clock) disable iff (rst) // [RQ2]
		(cfg_write && !config_stage && !otp_write && cfg_addr == ADDR_TIMEOUT) |=> $stable(r.timeout_code))
		else $error("timeout changed by a write outside the config stage");

	// Option A of port 5 enables after the select code is present
	a_p5_option_a: assert property (@(posedge clock) disable iff (rst) // [RQ5]
		(ce && r.sel5 == P5_OPT_A) |=> port5_option_a_pin_oe && !port5_option_b_pin_oe)
		else $error("port 5 option A pin not enabled");

	// Option B of port 6 enables after the select code is present
	a_p6_option_b: assert property (@(posedge clock) disable iff (rst) // [RQ6]
		(ce && r.sel6 == P6_OPT_B) |=> port6_option_b_pin_oe && !port6_option_a_pin_oe)
		else $error("port 6 option B pin not enabled");

	// A disabled timeout never starts a power-off pulse on port 5
	a_timeout_off: assert property (@(posedge clock) disable iff (rst) // [RQ10]
		(r.timeout_code == TO_NONE && mon_power[0]) |=> mon_power[0])
		else $error("link reset started with the timeout disabled");

	// The 1 s code decodes to one thousand milliseconds
	a_one_second: assert property (@(posedge clock) disable iff (rst) // [RQ11]
		r.timeout_code == TO_1S |-> timeout_ms == MS_1000)
		else $error("one second timeout code decoded wrongly");

	// Driven split pin mirrors the monitor's power level
	a_pin_mirrors: assert property (@(posedge clock) disable iff (rst) // [RQ4]
		(ce && r.p5a_oe && r.sel5 == P5_OPT_A) |=> port5_option_a_pin == $past(mon_power[0]))
		else $error("split pin does not mirror monitor power");

	// Unmapped reads return zero
	a_unmapped_zero: assert property (@(posedge clock) disable iff (rst) // [RQ1]
		(ce && cfg_read && cfg_addr != ADDR_PORT5_SEL && cfg_addr != ADDR_PORT6_SEL
		&& cfg_addr != ADDR_TIMEOUT && cfg_addr != ADDR_OFF_TIME) |=> cfg_rdata == RDATA_RESET)
		else $error("unmapped read returned data");

endmodule
`default_nettype wire

// file: rtl/split_link_monitor.sv
// Per-port link watchdog: counts stuck link states and pulses split power low.
// Assumes ms_tick is a one-cycle pulse per millisecond in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module split_link_monitor
(
	// Clock, reset and clock enable
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	// Timing and configuration
	input  wire logic        ms_tick,
	input  wire logic        split_enabled,
	input  wire logic [11:0] timeout_ms,
	input  wire logic [11:0] off_ms,
	// Link observation and power result
	input  wire logic [3:0]  link_state,
	output logic             power
);
	import split_pkg::*;

	typedef struct packed
	{
		mon_state_e  state;
		logic [11:0] count;
		logic [3:0]  last_state;
		logic        power;
	} mon_s;

	mon_s r;
	mon_s next_r;
	logic stuck;

	// A state counts as stuck only while it lies in the non-operational window
	assign stuck = (link_state >= LINK_STUCK_LO) && (link_state <= LINK_STUCK_HI); // [RQ9]
	assign power = r.power;

	// Next-state logic of the watchdog
	always_comb
	begin
		next_r            = r;
		next_r.last_state = link_state;
		case (r.state)
			MON_WATCH:
			begin
				next_r.power = 1'b1;
				// Any movement of the link restarts the wait: a live link switches often
				if (!split_enabled || timeout_ms == MS_NONE || !stuck || link_state != r.last_state) // [RQ9] [RQ10]
					next_r.count = MS_NONE;
				else if (ms_tick)
				begin
					if (12'(r.count + MS_ONE) >= timeout_ms) // [RQ7]
					begin
						next_r.state = MON_POWER_OFF;
						next_r.count = MS_NONE; // [RQ8]
						next_r.power = 1'b0;    // [RQ12]
					end
					else
						next_r.count = 12'(r.count + MS_ONE);
				end
			end
			MON_POWER_OFF:
			begin
				// Dropping the split setting abandons the pulse at once
				if (!split_enabled)
				begin
					next_r.state = MON_WATCH;
					next_r.count = MS_NONE;
					next_r.power = 1'b1;
				end
				else if (ms_tick)
				begin
					if (12'(r.count + MS_ONE) >= off_ms) // [RQ13]
					begin
						next_r.state = MON_WATCH; // [RQ15]
						next_r.count = MS_NONE;   // [RQ14]
						next_r.power = 1'b1;      // [RQ15]
					end
					else
						next_r.count = 12'(r.count + MS_ONE);
				end
			end
			default:
			begin
				next_r.state = MON_WATCH;
				next_r.count = MS_NONE;
				next_r.power = 1'b1;
			end
		endcase
	end

	// State register, frozen while ce is low
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			r.state      <= MON_WATCH;
			r.count      <= MS_NONE;
			r.last_state <= 4'h0;
			r.power      <= 1'b1;
		end
		else if (ce)
			r <= next_r;
	end

	// Power only falls after a full stuck timeout
	a_fall_after_timeout: assert property (@(posedge clock) disable iff (rst) // [RQ7]
		$fell(r.power) |-> ($past(timeout_ms) != MS_NONE) && (12'($past(r.count) + MS_ONE) >= $past(timeout_ms))
		&& r.count == MS_NONE && r.state == MON_POWER_OFF)
		else $error("split power fell before the link timeout");

	// Power low pulse not shorter than the programmed duration
	a_off_duration: assert property (@(posedge clock) disable iff (rst) // [RQ13]
		($rose(r.power) && $past(split_enabled)) |-> (12'($past(r.count) + MS_ONE) >= $past(off_ms)))
		else $error("split power low pulse ended early");

	// Restart of monitoring with a cleared timer
	a_restart_clean: assert property (@(posedge clock) disable iff (rst) // [RQ15]
		$rose(r.power) |-> (r.state == MON_WATCH && r.count == MS_NONE))
		else $error("monitoring resumed without a cleared timer");

	// Link state change clears the stuck count
	a_change_clears: assert property (@(posedge clock) disable iff (rst) // [RQ9]
		(ce && r.state == MON_WATCH && link_state != r.last_state) |=> r.count == MS_NONE)
		else $error("stuck count survived a link state change");

	// Power is low only while the pulse runs
	a_low_means_off: assert property (@(posedge clock) disable iff (rst) // [RQ12]
		!r.power |-> r.state == MON_POWER_OFF)
		else $error("split power low outside a reset pulse");

endmodule
`default_nettype wire

// file: rtl/split_pkg.sv
// Constants, register map and state codes for the port-split link recovery block.
// Assumes a single 10 MHz hub clock; timer values are kept in millisecond units, the tick derivation in nanoseconds.
`default_nettype none
package split_pkg;

	// Register addresses in the hub configuration space
	localparam logic [15:0] ADDR_PORT5_SEL  = 16'h416D;
	localparam logic [15:0] ADDR_PORT6_SEL  = 16'h416E;
	localparam logic [15:0] ADDR_TIMEOUT    = 16'h4171;
	localparam logic [15:0] ADDR_OFF_TIME   = 16'h4176;

	// Split pin select codes
	localparam logic [7:0]  P5_OPT_A        = 8'h42;
	localparam logic [7:0]  P5_OPT_B        = 8'h05;
	localparam logic [7:0]  P6_OPT_A        = 8'h06;
	localparam logic [7:0]  P6_OPT_B        = 8'h04;

	// Reset values
	localparam logic [7:0]  SEL_RESET       = 8'h00;
	localparam logic [2:0]  TIMEOUT_RESET   = 3'h5;
	localparam logic [7:0]  OFF_TIME_RESET  = 8'h05;
	localparam logic [7:0]  RDATA_RESET     = 8'h00;

	// Timeout field codes
	localparam logic [2:0]  TO_NONE         = 3'h0;
	localparam logic [2:0]  TO_100MS        = 3'h1;
	localparam logic [2:0]  TO_250MS        = 3'h2;
	localparam logic [2:0]  TO_750MS        = 3'h3;
	localparam logic [2:0]  TO_1S           = 3'h5;
	localparam logic [2:0]  TO_2S           = 3'h6;

	// Times in milliseconds
	localparam logic [11:0] MS_NONE         = 12'h000;
	localparam logic [11:0] MS_100          = 12'h064;
	localparam logic [11:0] MS_250          = 12'h0FA;
	localparam logic [11:0] MS_750          = 12'h2EE;
	localparam logic [11:0] MS_1000         = 12'h3E8;
	localparam logic [11:0] MS_2000         = 12'h7D0;
	localparam logic [11:0] OFF_BASE_MS     = 12'h15E;
	localparam logic [11:0] OFF_STEP_MS     = 12'h00A;
	localparam logic [11:0] MS_ONE          = 12'h001;

	// Stuck link state window
	localparam logic [3:0]  LINK_STUCK_LO   = 4'h4;
	localparam logic [3:0]  LINK_STUCK_HI   = 4'h9;

	// Millisecond tick derived from the clock period
	localparam int          CLOCK_PERIOD_NS = 100;
	localparam int          MS_NS           = 1000000;
	localparam int          MS_CYCLES       = MS_NS / CLOCK_PERIOD_NS;
	localparam logic [15:0] TICK_ONE        = 16'h0001;
	localparam logic [15:0] TICK_ZERO       = 16'h0000;

	typedef enum logic [1:0]
	{
		MON_WATCH     = 2'b01,
		MON_POWER_OFF = 2'b10
	} mon_state_e;

endpackage
`default_nettype wire

// file: sim/port_split_link_recovery_tb_top.sv
// Self-checking bench for split power control with two embedded device models.
// Assumes TICK_CYCLES of 4, so one millisecond is four clocks of 100 ns.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module port_split_link_recovery_tb_top;
	import split_pkg::*;
	localparam int TK = 4;
	logic        clock;
	logic        rst;
	logic        ce;
	logic        config_stage;
	logic        cfg_write;
	logic        otp_write;
	logic        cfg_read;
	logic [15:0] cfg_addr;
	logic [7:0]  cfg_wdata;
	wire  [7:0]  cfg_rdata;
	logic [1:0]  port_power_request;
	wire  [1:0]  port_power_control_pin;
	wire  [3:0]  ls5;
	wire  [3:0]  ls6;
	wire  [3:0]  pin;
	wire  [3:0]  oe;
	wire  [1:0]  level;
	logic [1:0]  stuck;
	logic [3:0]  stuck_code;
	int          err_count;
	int          comparisons;

	// Released pins read low: the device supply has a pull-down
	assign level[0] = (oe[3] & pin[3]) | (oe[2] & pin[2]);
	assign level[1] = (oe[1] & pin[1]) | (oe[0] & pin[0]);

	port_split_link_recovery #(.TICK_CYCLES(TK)) u_port_split_link_recovery
	(
		.clock(clock), .rst(rst), .ce(ce), .config_stage(config_stage), .cfg_write(cfg_write),
		.otp_write(otp_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .port_power_request(port_power_request),
		.port_power_control_pin(port_power_control_pin), .link_state_status_p5(ls5),
		.link_state_status_p6(ls6), .port5_option_a_pin(pin[3]), .port5_option_a_pin_oe(oe[3]),
		.port5_option_b_pin(pin[2]), .port5_option_b_pin_oe(oe[2]), .port6_option_a_pin(pin[1]),
		.port6_option_a_pin_oe(oe[1]), .port6_option_b_pin(pin[0]), .port6_option_b_pin_oe(oe[0])
	);
	split_device_model u_device_p5
	(
		.clock(clock), .rst(rst), .power(level[0]), .stuck(stuck[0]), .stuck_code(stuck_code), .link_state(ls5)
	);
	split_device_model u_device_p6
	(
		.clock(clock), .rst(rst), .power(level[1]), .stuck(stuck[1]), .stuck_code(stuck_code), .link_state(ls6)
	);

	// Free-running 10 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic complete_run();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One-cycle write strobe; strobe dropped before the next call can raise it
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic stage, input logic otp);
		@(posedge clock);
		cfg_addr <= a;
		cfg_wdata <= d;
		config_stage <= stage;
		cfg_write <= !otp;
		otp_write <= otp;
		@(posedge clock);
		cfg_write <= 1'b0;
		otp_write <= 1'b0;
		config_stage <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clock);
		cfg_addr <= a;
		cfg_read <= 1'b1;
		@(posedge clock);
		cfg_read <= 1'b0;
		#1;
		`CHECK(cfg_rdata, e)
	endtask

	// Bounded wait for a split supply level; a timeout ends the run
	task automatic wait_lvl(input int p, input logic v, input int lim, output int n);
		n = 0;
		while (level[p] !== v)
		begin
			@(posedge clock);
			#1;
			n++;
			if (n > lim)
			begin
				`CHECK(level[p], v)
				complete_run();
			end
		end
	endtask

	task automatic test_reset_values();
		`CHECK(oe, 4'h0)
		rd(ADDR_PORT5_SEL, SEL_RESET);
		rd(ADDR_PORT6_SEL, SEL_RESET);
		rd(ADDR_TIMEOUT, 8'h05);
		rd(ADDR_OFF_TIME, OFF_TIME_RESET);
		rd(16'h416F, RDATA_RESET);
		$display("test_reset_values done");
	endtask

	task automatic test_config_access();
		wr(ADDR_PORT5_SEL, P5_OPT_A, 1'b0, 1'b0);
		rd(ADDR_PORT5_SEL, SEL_RESET);
		wr(ADDR_TIMEOUT, 8'h01, 1'b0, 1'b0);
		rd(ADDR_TIMEOUT, {5'h00, TIMEOUT_RESET});
		wr(ADDR_TIMEOUT, 8'hFB, 1'b0, 1'b1);
		rd(ADDR_TIMEOUT, 8'h03);
		wr(16'h416C, P5_OPT_A, 1'b1, 1'b0);
		repeat (2) @(posedge clock);
		#1;
		`CHECK(oe, 4'h0)
		wr(ADDR_PORT5_SEL, P5_OPT_A, 1'b1, 1'b0);
		rd(ADDR_PORT5_SEL, P5_OPT_A);
		wr(ADDR_PORT5_SEL, SEL_RESET, 1'b1, 1'b0);
		$display("test_config_access done");
	endtask

	// Every select code, plus each port's option A code written to the other port
	task automatic test_pin_select();
		logic [15:0] ad[6] = '{ADDR_PORT5_SEL, ADDR_PORT5_SEL, ADDR_PORT6_SEL, ADDR_PORT6_SEL,
			ADDR_PORT5_SEL, ADDR_PORT6_SEL};
		logic [7:0]  cd[6] = '{P5_OPT_A, P5_OPT_B, P6_OPT_A, P6_OPT_B, P6_OPT_A, P5_OPT_A};
		logic [3:0]  ex[6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0};
		for (int i = 0; i < 6; i++)
		begin
			wr(ad[i], cd[i], 1'b1, 1'b0);
			port_power_request <= 2'(i);
			repeat (2) @(posedge clock);
			#1;
			`CHECK(oe, ex[i])
			`CHECK(pin, ex[i])
			`CHECK(port_power_control_pin, 2'(i))
			wr(ad[i], SEL_RESET, 1'b1, 1'b0);
		end
		$display("test_pin_select done");
	endtask

	// Stuck link: first drop, low width, repeat drop, second low width
	task automatic test_link_recovery();
		int         n;
		int         oms;
		int         p[7]   = '{0, 1, 0, 1, 0, 1, 1};
		logic [7:0] sc[7]  = '{P5_OPT_A, P6_OPT_B, P5_OPT_B, P6_OPT_A, P5_OPT_A, P6_OPT_B, P6_OPT_A};
		logic [7:0] tc[7]  = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h01, 8'h01};
		logic [3:0] lc[7]  = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h4};
		logic [7:0] of[7]  = '{8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h00, 8'hFF};
		int         tms[7] = '{100, 250, 750, 1000, 2000, 100, 100};
		port_power_request <= 2'b11;
		for (int i = 0; i < 7; i++)
		begin
			oms = 350 + 10 * int'(of[i]);
			wr(ADDR_TIMEOUT, tc[i], 1'b1, 1'b0);
			wr(ADDR_OFF_TIME, of[i], 1'b0, 1'b1);
			wr(p[i] ? ADDR_PORT6_SEL : ADDR_PORT5_SEL, sc[i], 1'b1, 1'b0);
			wait_lvl(p[i], 1'b1, 8, n);
			repeat (40) @(posedge clock);
			stuck[p[i]] <= 1'b1;
			stuck_code <= lc[i];
			wait_lvl(p[i], 1'b0, tms[i] * TK + 12, n);
			`CHECK(n >= tms[i] * TK - 8, 1'b1)
			`CHECK(port_power_control_pin, 2'b11)
			wait_lvl(p[i], 1'b1, oms * TK + 8, n);
			`CHECK(n >= oms * TK - 8, 1'b1)
			wait_lvl(p[i], 1'b0, tms[i] * TK + 40, n);
			`CHECK(n >= tms[i] * TK - 8, 1'b1)
			wait_lvl(p[i], 1'b1, oms * TK + 8, n);
			`CHECK(n >= oms * TK - 8, 1'b1)
			stuck[p[i]] <= 1'b0;
			wr(p[i] ? ADDR_PORT6_SEL : ADDR_PORT5_SEL, SEL_RESET, 1'b1, 1'b0);
		end
		$display("test_link_recovery done");
	endtask

	// Disabled codes and a non-stuck state must never drop the supply
	task automatic test_no_reset();
		int         n;
		int         lows;
		logic [7:0] tc[4] = '{8'h00, 8'h07, 8'h01, 8'h04};
		logic [3:0] lc[4] = '{4'h5, 4'h5, 4'hA, 4'h5};
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_TIMEOUT, tc[i], 1'b1, 1'b0);
			wr(ADDR_PORT5_SEL, P5_OPT_A, 1'b1, 1'b0);
			wait_lvl(0, 1'b1, 8, n);
			stuck[0] <= 1'b1;
			stuck_code <= lc[i];
			lows = 0;
			repeat (600)
			begin
				@(posedge clock);
				#1;
				lows += int'(level[0] === 1'b0);
			end
			`CHECK(lows, 0)
			stuck[0] <= 1'b0;
			wr(ADDR_PORT5_SEL, SEL_RESET, 1'b1, 1'b0);
		end
		$display("test_no_reset done");
	endtask

	// Main sequence
	initial
	begin
		err_count = 0;
		comparisons = 0;
		rst = 1'b1;
		ce = 1'b1;
		config_stage = 1'b0;
		cfg_write = 1'b0;
		otp_write = 1'b0;
		cfg_read = 1'b0;
		cfg_addr = 16'h0000;
		cfg_wdata = 8'h00;
		port_power_request = 2'b00;
		stuck = 2'b00;
		stuck_code = 4'h0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		test_reset_values();
		test_config_access();
		test_pin_select();
		test_link_recovery();
		test_no_reset();
		complete_run();
	end
endmodule
`default_nettype wire

// file: sim/split_device_model.sv
// Behavioural embedded USB 3.x device powered from one split power pin.
// Assumes power is the resolved pin level, low when the pin is released.
`timescale 1ns/10ps
`default_nettype none
module split_device_model
#(
	parameter int TRAIN_CYCLES = 20
)
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Supply and commanded behaviour
	input  wire logic       power,
	input  wire logic       stuck,
	input  wire logic [3:0] stuck_code,
	// Link state as the hub sees it
	output logic      [3:0] link_state
);
	int unsigned train;

	// Unpowered: hub only sees receiver detect; powered: polls, then U0 or a hang
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst || !power)
		begin
			train <= 0;
			link_state <= 4'h5;
		end
		else if (train < TRAIN_CYCLES)
		begin
			train <= train + 1;
			link_state <= 4'h7;
		end
		else
			link_state <= stuck ? stuck_code : 4'h0;  // A hang repeats one code forever
	end
endmodule
`default_nettype wire
